// [verilog/psl_pkg.sv]
`default_nettype none
package psl_pkg;
	// Bus and datapath widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W  = 8;
	localparam int PIX_W  = 16;
	localparam int IDX_W  = 10;
	// Register indices; the byte address is four times the index
	localparam logic [9:0] IDX_REFRESH   = 10'h021;
	localparam logic [9:0] IDX_DISP_MODE = 10'h040;
	localparam logic [9:0] IDX_DUAL_BUF  = 10'h041;
	localparam logic [9:0] IDX_BIAS_CTRL = 10'h1E0;
	localparam logic [9:0] IDX_PS_CFG    = 10'h1F0;
	localparam logic [9:0] IDX_PS_STATE  = 10'h1F1;
	// Field positions
	localparam int PS_EN_BIT      = 0;
	localparam int STAT_MEM_BIT   = 0;
	localparam int STAT_PANEL_BIT = 1;
	localparam int REF_SEL_HI     = 7;
	localparam int REF_SEL_LO     = 6;
	localparam int BLANK_BIT      = 7;
	localparam int DUAL_DIS_BIT   = 0;
	localparam int BIAS_PIN_BIT   = 0;
	localparam int BIAS_MAN_BIT   = 1;
	// Values after reset and writable bits
	localparam logic [7:0] RST_REG      = 8'h00;
	localparam logic [7:0] MASK_REFRESH = 8'hC7;
	localparam logic [7:0] MASK_DISP    = 8'h97;
	localparam logic [7:0] MASK_ONE     = 8'h01;
	localparam logic [7:0] MASK_BIAS    = 8'h03;
	// Refresh select codes; any code with the top bit set means none
	localparam logic [1:0] REF_CBR  = 2'h0;
	localparam logic [1:0] REF_SELF = 2'h1;
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Panel bias discharge delay
	localparam int CLK_MHZ         = 25;
	localparam int PANEL_DELAY_US  = 500000;
	localparam int PANEL_DELAY_CYC = PANEL_DELAY_US * CLK_MHZ;
	localparam int DLY_W           = 24;
	// Panel power sequencer states
	typedef enum logic [1:0] {
		SEQ_OFF      = 2'b00,
		SEQ_SIG_ON   = 2'b01,
		SEQ_ON       = 2'b10,
		SEQ_BIAS_OFF = 2'b11
	} psl_seq_t;
endpackage : psl_pkg
`default_nettype wire

// [verilog/psl_delay.sv]
`timescale 1ns/1ps
`default_nettype none
module psl_delay #(
	parameter int CYC = 4
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic start,
	output logic      busy,
	output logic      done
);
	logic [psl_pkg::DLY_W-1:0] cnt_r;
	logic                      busy_r;
	logic                      done_r;

	assign busy = busy_r;
	assign done = done_r;

	// Loads on start, counts down, pulses done once at zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn) begin
			cnt_r  <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			// A fresh start must not see the end of an earlier count
			done_r <= busy_r && (cnt_r == '0) && !start;
			if (start) begin
				cnt_r  <= psl_pkg::DLY_W'(CYC - 1);
				busy_r <= 1'b1;
			end else if (busy_r) begin
				cnt_r  <= cnt_r - 1'b1;
				busy_r <= (cnt_r != '0);
			end
		end
	end
endmodule : psl_delay
`default_nettype wire

// [verilog/psl_axil.sv]
`timescale 1ns/1ps
`default_nettype none
module psl_axil (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [psl_pkg::ADDR_W-1:0]  awaddr,
	input  wire logic                        awvalid,
	output logic                             awready,
	input  wire logic [psl_pkg::DATA_W-1:0]  wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	output logic [1:0]                       bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	input  wire logic [psl_pkg::ADDR_W-1:0]  araddr,
	input  wire logic                        arvalid,
	output logic                             arready,
	output logic [psl_pkg::DATA_W-1:0]       rdata,
	output logic [1:0]                       rresp,
	output logic                             rvalid,
	input  wire logic                        rready,
	output logic                             wr_en,
	output logic [psl_pkg::IDX_W-1:0]        wr_idx,
	output logic [psl_pkg::REG_W-1:0]        wr_byte,
	input  wire logic                        wr_hit,
	output logic [psl_pkg::IDX_W-1:0]        rd_idx,
	input  wire logic [psl_pkg::REG_W-1:0]   rd_byte,
	input  wire logic                        rd_hit
);
	logic [psl_pkg::ADDR_W-1:0] addr_r;
	logic [psl_pkg::DATA_W-1:0] data_r;
	logic [3:0]                 strb_r;
	logic                       aw_held_r, w_held_r, awready_r, wready_r;
	logic                       bvalid_r, arready_r, rvalid_r;
	logic [1:0]                 bresp_r, rresp_r;
	logic [psl_pkg::DATA_W-1:0] rdata_r;
	wire aw_take = awvalid && awready_r;
	wire w_take  = wvalid && wready_r;
	wire do_wr   = (aw_held_r || aw_take) && (w_held_r || w_take);
	wire bvalid_nxt = do_wr || (bvalid_r && !bready);
	wire ar_take = arvalid && arready_r;
	wire rvalid_nxt = ar_take || (rvalid_r && !rready);
	wire [3:0] strb_w = w_take ? wstrb : strb_r;

	// Address and data may arrive in either order
	assign wr_idx  = aw_take ? awaddr[11:2] : addr_r[11:2];
	assign wr_byte = w_take ? wdata[7:0] : data_r[7:0];
	assign wr_en   = do_wr && strb_w[0];
	assign rd_idx  = araddr[11:2];
	assign awready = awready_r;
	assign wready  = wready_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign arready = arready_r;
	assign rvalid  = rvalid_r;
	assign rresp   = rresp_r;
	assign rdata   = rdata_r;

	// Write channel: one write under way at a time
	always_ff @(posedge aclk)
	begin
		if (!aresetn) begin
			{aw_held_r, w_held_r, bvalid_r} <= 3'h0;
			{awready_r, wready_r} <= 2'h3;
			{addr_r, data_r, strb_r, bresp_r} <= '0;
		end else begin
			if (aw_take) addr_r <= awaddr;
			if (w_take) {data_r, strb_r} <= {wdata, wstrb};
			aw_held_r <= (aw_held_r || aw_take) && !do_wr;
			w_held_r  <= (w_held_r || w_take) && !do_wr;
			awready_r <= !bvalid_nxt && !(aw_held_r || aw_take);
			wready_r  <= !bvalid_nxt && !(w_held_r || w_take);
			bvalid_r  <= bvalid_nxt;
			if (do_wr) bresp_r <= wr_hit ? psl_pkg::RESP_OKAY
			                             : psl_pkg::RESP_SLVERR;
		end
	end

	// Read channel: data captured on the address edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn) begin
			{rvalid_r, rresp_r, rdata_r} <= '0;
			arready_r <= 1'b1;
		end else begin
			rvalid_r  <= rvalid_nxt;
			arready_r <= !rvalid_nxt;
			if (ar_take) begin
				rdata_r <= {24'h000000, rd_byte};
				rresp_r <= rd_hit ? psl_pkg::RESP_OKAY : psl_pkg::RESP_SLVERR;
			end
		end
	end
endmodule : psl_axil
`default_nettype wire

// [verilog/psl_sequencer.sv]
// Behaviour
// - Power save enable bit 0 written 1 enters power save, 0 leaves it.
// - In power save displays off, memory refused, registers and lookup table open.
// - Entering power save runs the automatic panel power-down sequence.
// - Panel status reads 1 only when panel fully off, else 0.
// - Panel status reads 1 after reset.
// - Memory controller status reads 1 when the DRAM interface is down.
// - Memory controller status reads 0 after reset.
// - Memory controller status reaches 1 only with self-refresh or no refresh.
// - Refresh select 00 cas-first, 01 self-refresh, 1X none in power save.
// - Cas-first refresh keeps memory controller powered; memory clock keeps running.
// - Self or no refresh lets the controller power down; clock may stop.
// - Signals stay until bias off plus delay; signals come before bias.
// - Display blank bit stops the pipeline and zeroes the panel data output.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module psl_sequencer #(
	parameter int DELAY_CYC = psl_pkg::PANEL_DELAY_CYC
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [psl_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [psl_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [psl_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [psl_pkg::DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic [psl_pkg::PIX_W-1:0]  pixel_in,
	input  wire logic                       mem_req,
	output logic [psl_pkg::PIX_W-1:0]       panel_data,
	output logic                            panel_signals_en,
	output logic                            panel_bias_enable_pin,
	output logic                            display_en,
	output logic                            dual_buf_dis,
	output logic                            mem_grant,
	output logic                            mem_refuse,
	output logic                            dram_cas_first_refresh,
	output logic                            dram_self_refresh,
	output logic                            memctl_down
);
	logic [psl_pkg::REG_W-1:0] refresh_r, disp_r, dual_r, bias_ctrl_r, ps_r;
	logic [psl_pkg::PIX_W-1:0] panel_data_r;
	logic                      sig_r, bias_r, panel_off_r, memdown_r;
	logic                      display_en_r, grant_r, refuse_r;
	logic                      cbr_r, self_r;
	psl_pkg::psl_seq_t         state_r, state_nxt;
	logic                      wr_en, wr_hit, rd_hit;
	logic [psl_pkg::IDX_W-1:0] wr_idx, rd_idx;
	logic [psl_pkg::REG_W-1:0] wr_byte, rd_byte;
	logic                      dly_start, dly_busy, dly_done;

	// Bus slave: decode and handshakes
	psl_axil u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.wr_en   (wr_en),
		.wr_idx  (wr_idx),
		.wr_byte (wr_byte),
		.wr_hit  (wr_hit),
		.rd_idx  (rd_idx),
		.rd_byte (rd_byte),
		.rd_hit  (rd_hit)
	);

	// Discharge and settle delay counter
	psl_delay #(
		.CYC (DELAY_CYC)
	) u_delay (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (dly_start),
		.busy    (dly_busy),
		.done    (dly_done)
	);

	// Register decode; registers stay reachable in power save
	wire w_refresh = wr_en && (wr_idx == psl_pkg::IDX_REFRESH);
	wire w_disp    = wr_en && (wr_idx == psl_pkg::IDX_DISP_MODE);
	wire w_dual    = wr_en && (wr_idx == psl_pkg::IDX_DUAL_BUF);
	wire w_bias    = wr_en && (wr_idx == psl_pkg::IDX_BIAS_CTRL);
	wire w_ps      = wr_en && (wr_idx == psl_pkg::IDX_PS_CFG);
	assign wr_hit = (wr_idx == psl_pkg::IDX_REFRESH)
		|| (wr_idx == psl_pkg::IDX_DISP_MODE)
		|| (wr_idx == psl_pkg::IDX_DUAL_BUF)
		|| (wr_idx == psl_pkg::IDX_BIAS_CTRL)
		|| (wr_idx == psl_pkg::IDX_PS_CFG);
	// Reads reach the writable registers and the status byte
	wire wr_hit_rd = (rd_idx == psl_pkg::IDX_REFRESH)
		|| (rd_idx == psl_pkg::IDX_DISP_MODE)
		|| (rd_idx == psl_pkg::IDX_DUAL_BUF)
		|| (rd_idx == psl_pkg::IDX_BIAS_CTRL)
		|| (rd_idx == psl_pkg::IDX_PS_CFG);
	assign rd_hit = wr_hit_rd || (rd_idx == psl_pkg::IDX_PS_STATE);

	// Status byte shows panel and memory interface power state
	wire [7:0] status_w = {6'h00, panel_off_r, memdown_r};
	assign rd_byte =
		(rd_idx == psl_pkg::IDX_REFRESH)   ? refresh_r   :
		(rd_idx == psl_pkg::IDX_DISP_MODE) ? disp_r      :
		(rd_idx == psl_pkg::IDX_DUAL_BUF)  ? dual_r      :
		(rd_idx == psl_pkg::IDX_BIAS_CTRL) ? bias_ctrl_r :
		(rd_idx == psl_pkg::IDX_PS_CFG)    ? ps_r        :
		(rd_idx == psl_pkg::IDX_PS_STATE)  ? status_w    : 8'h00;

	// Software-written registers; unused bits read as zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn) begin
			refresh_r   <= psl_pkg::RST_REG;
			disp_r      <= psl_pkg::RST_REG;
			dual_r      <= psl_pkg::RST_REG;
			bias_ctrl_r <= psl_pkg::RST_REG;
			ps_r        <= psl_pkg::RST_REG;
		end else begin
			if (w_refresh) refresh_r <= wr_byte & psl_pkg::MASK_REFRESH;
			if (w_disp) disp_r <= wr_byte & psl_pkg::MASK_DISP;
			if (w_dual) dual_r <= wr_byte & psl_pkg::MASK_ONE;
			if (w_bias) bias_ctrl_r <= wr_byte & psl_pkg::MASK_BIAS;
			if (w_ps) ps_r <= wr_byte & psl_pkg::MASK_ONE;
		end
	end

	// Named control levels
	wire       ps_en   = ps_r[psl_pkg::PS_EN_BIT];
	wire       blank   = disp_r[psl_pkg::BLANK_BIT];
	wire       man_sel = bias_ctrl_r[psl_pkg::BIAS_MAN_BIT];
	wire       man_pin = bias_ctrl_r[psl_pkg::BIAS_PIN_BIT];
	wire [1:0] ref_sel = refresh_r[psl_pkg::REF_SEL_HI:psl_pkg::REF_SEL_LO];

	// Delay starts on power-up from off and on power-down from on
	assign dly_start = ((state_r == psl_pkg::SEQ_OFF) && !ps_en)
		|| ((state_r == psl_pkg::SEQ_ON) && ps_en);

	// Panel power sequence: signals lead bias up, trail bias down
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			psl_pkg::SEQ_OFF:
				if (!ps_en) state_nxt = psl_pkg::SEQ_SIG_ON;
			psl_pkg::SEQ_SIG_ON:
				if (ps_en) state_nxt = psl_pkg::SEQ_OFF;
				else if (dly_done) state_nxt = psl_pkg::SEQ_ON;
			psl_pkg::SEQ_ON:
				if (ps_en) state_nxt = psl_pkg::SEQ_BIAS_OFF;
			psl_pkg::SEQ_BIAS_OFF:
				if (dly_done) state_nxt = psl_pkg::SEQ_OFF;
		endcase
	end

	// Sequencer state and panel power levels
	always_ff @(posedge aclk)
	begin
		if (!aresetn) begin
			state_r     <= psl_pkg::SEQ_OFF;
			sig_r       <= 1'b0;
			bias_r      <= 1'b0;
			panel_off_r <= 1'b1;
		end else begin
			state_r     <= state_nxt;
			sig_r       <= (state_nxt != psl_pkg::SEQ_OFF);
			bias_r      <= (state_nxt == psl_pkg::SEQ_ON);
			panel_off_r <= (state_nxt == psl_pkg::SEQ_OFF);
		end
	end

	// Manual mode hands the bias pin to software
	logic pin_r;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pin_r <= 1'b0;
		else
			pin_r <= man_sel ? man_pin : (state_nxt == psl_pkg::SEQ_ON);
	end

	// Display pipeline, blanking and memory access gate
	always_ff @(posedge aclk)
	begin
		if (!aresetn) begin
			display_en_r <= 1'b0;
			panel_data_r <= '0;
			grant_r      <= 1'b0;
			refuse_r     <= 1'b0;
		end else begin
			display_en_r <= !ps_en && !blank && sig_r;
			panel_data_r <= (!ps_en && !blank && sig_r) ? pixel_in : '0;
			grant_r      <= mem_req && !ps_en;
			refuse_r     <= mem_req && ps_en;
		end
	end

	// DRAM refresh type and memory controller power state
	wire sel_cbr  = (ref_sel == psl_pkg::REF_CBR);
	wire sel_self = (ref_sel == psl_pkg::REF_SELF);
	always_ff @(posedge aclk)
	begin
		if (!aresetn) begin
			cbr_r     <= 1'b0;
			self_r    <= 1'b0;
			memdown_r <= 1'b0;
		end else begin
			cbr_r     <= ps_en && sel_cbr;
			self_r    <= ps_en && sel_self;
			memdown_r <= ps_en && !sel_cbr;
		end
	end

	assign panel_data             = panel_data_r;
	assign panel_signals_en       = sig_r;
	assign panel_bias_enable_pin  = pin_r;
	assign display_en             = display_en_r;
	assign dual_buf_dis           = dual_r[psl_pkg::DUAL_DIS_BIT];
	assign mem_grant              = grant_r;
	assign mem_refuse             = refuse_r;
	assign dram_cas_first_refresh = cbr_r;
	assign dram_self_refresh      = self_r;
	assign memctl_down            = memdown_r;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Power save write followed by its effect on the enable bit
	sequence s_ps_write;
		w_ps;
	endsequence
	sequence s_enter_down;
		((state_r == psl_pkg::SEQ_BIAS_OFF) && !bias_r && sig_r)
		##1 ((state_r == psl_pkg::SEQ_BIAS_OFF) && sig_r);
	endsequence
	// Power-up from off: signals first, bias off, status cleared
	sequence s_power_up;
		(state_r == psl_pkg::SEQ_SIG_ON) && sig_r && !bias_r
		&& !panel_off_r;
	endsequence

	// Power save entry, exit and access gating
	AST_PS_WRITE: assert property (
		s_ps_write |=> (ps_en == $past(wr_byte[0])))
		else $error("power save bit does not follow the write");
	AST_PS_BLOCKS: assert property (
		ps_en |=> (!display_en_r && !grant_r && (refuse_r == $past(mem_req))))
		else $error("display or memory active in power save");
	AST_ENTER_SEQ: assert property (
		((state_r == psl_pkg::SEQ_ON) && ps_en) |=> s_enter_down)
		else $error("power save entry skipped the power-down sequence");
	AST_PIN_AUTO: assert property (
		(!man_sel && ps_en && (state_r == psl_pkg::SEQ_ON)) |=> !pin_r)
		else $error("bias pin still on after power save entry");
	AST_POWER_UP: assert property (
		((state_r == psl_pkg::SEQ_OFF) && !ps_en) |=> s_power_up)
		else $error("power save exit did not start the power-up");
	AST_ACCESS_BACK: assert property (
		!ps_en |=> ((grant_r == $past(mem_req)) && !refuse_r))
		else $error("memory access not restored outside power save");
	AST_DISPLAY_ON: assert property (
		(!ps_en && !blank && sig_r) |=> display_en_r)
		else $error("display not restored after power save");
	AST_STATUS_OFF: assert property (
		panel_off_r == (!sig_r && !bias_r))
		else $error("panel status disagrees with panel power");
	AST_RESET_STATUS: assert property (
		$rose(aresetn) |-> (panel_off_r && !memdown_r))
		else $error("status wrong after reset");

	// Refresh type and memory controller power
	AST_MEM_DOWN_SEL: assert property (
		memdown_r |-> ($past(ref_sel) != psl_pkg::REF_CBR))
		else $error("controller down under cas-first refresh");
	AST_REFRESH_TYPE: assert property (
		(ps_en && sel_cbr) |=> (cbr_r && !self_r && !memdown_r))
		else $error("cas-first refresh not applied");
	AST_SELF_TYPE: assert property (
		(ps_en && sel_self) |=> (self_r && !cbr_r && memdown_r))
		else $error("self-refresh not applied");
	AST_NO_REFRESH: assert property (
		(ps_en && ref_sel[1]) |=> (!self_r && !cbr_r && memdown_r))
		else $error("no-refresh choice not applied");
	AST_CBR_KEEPS_UP: assert property (
		cbr_r |-> !memdown_r)
		else $error("controller down while cas-first refresh runs");
	AST_NORMAL_MEM: assert property (
		!ps_en |=> (!memdown_r && !cbr_r && !self_r))
		else $error("memory interface down outside power save");

	// Panel power order, delay and blanking
	AST_BIAS_NEEDS_SIG: assert property (
		bias_r |-> sig_r)
		else $error("bias on without panel signals");
	AST_BIAS_LEADS: assert property (
		$rose(bias_r)
		|-> ($past(sig_r) && ($past(state_r) == psl_pkg::SEQ_SIG_ON)))
		else $error("bias rose without a signal lead time");
	AST_SIG_ON_NO_BIAS: assert property (
		(state_r == psl_pkg::SEQ_SIG_ON) |-> !bias_r)
		else $error("bias on during the signal lead time");
	AST_SIG_HOLD: assert property (
		((state_r == psl_pkg::SEQ_BIAS_OFF) && dly_busy) |=> sig_r)
		else $error("signals dropped before discharge delay");
	AST_DLY_START: assert property (
		dly_start |=> dly_busy)
		else $error("discharge delay did not start");
	AST_DONE_PULSE: assert property (
		dly_done |=> !dly_done)
		else $error("delay done held longer than one cycle");
	AST_PANEL_OFF_ONLY: assert property (
		panel_off_r |-> (state_r == psl_pkg::SEQ_OFF))
		else $error("panel status set while panel not off");
	AST_BLANK: assert property (
		blank |=> ((panel_data_r == '0) && !display_en_r))
		else $error("panel data not zero while blanked");
endmodule : psl_sequencer
`default_nettype wire

// [bench/psl_panel_model.sv]
`timescale 1ns/1ps
`default_nettype none
module psl_panel_model (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic panel_signals_en,
	input  wire logic panel_bias_enable_pin,
	input  wire logic dram_cas_first_refresh,
	input  wire logic memctl_down,
	output logic      mem_clk_run,
	output logic      pix_clk_run,
	output logic      seq_fault
);
	// Memory clock stops only once the controller is down
	assign mem_clk_run = !memctl_down;
	// Pixel clock stops only once the panel signals are off
	assign pix_clk_run = panel_signals_en;
	// Flags a panel or memory power order that would harm the far side
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			seq_fault <= 1'b0;
		else if ($fell(panel_signals_en) && panel_bias_enable_pin)
			seq_fault <= 1'b1;
		else if ($rose(panel_bias_enable_pin) && !panel_signals_en)
			seq_fault <= 1'b1;
		else if (memctl_down && dram_cas_first_refresh)
			seq_fault <= 1'b1;
	end
endmodule : psl_panel_model
`default_nettype wire

// [bench/power_save_lcd_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module power_save_lcd_sequencer_tb;
	localparam int DLY = 8;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, mem_req, panel_signals_en;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, panel_bias_enable_pin, display_en, dual_buf_dis;
	logic        mem_grant, mem_refuse, dram_cas_first_refresh;
	logic        dram_self_refresh, memctl_down, mem_clk_run, seq_fault, req_d;
	logic        pix_clk_run;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [15:0] pixel_in, panel_data, pix_d;
	int          errors, n_checks, gap, g0;

	psl_sequencer #(.DELAY_CYC(DLY)) psl_sequencer_inst (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .pixel_in, .mem_req, .panel_data,
		.panel_signals_en, .panel_bias_enable_pin, .display_en, .dual_buf_dis,
		.mem_grant, .mem_refuse, .dram_cas_first_refresh, .dram_self_refresh,
		.memctl_down);
	psl_panel_model psl_panel_model_inst (
		.aclk, .aresetn, .panel_signals_en, .panel_bias_enable_pin,
		.dram_cas_first_refresh, .memctl_down, .mem_clk_run, .seq_fault,
		.pix_clk_run);

	// Clock at 25 MHz
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// Repeatable random source
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Display-side traffic and its one-cycle history
	always @(posedge aclk)
	begin
		pixel_in <= xs();
		mem_req <= seed[20];
		pix_d <= pixel_in;
		req_d <= mem_req;
		if (!panel_bias_enable_pin && panel_signals_en)
			gap <= gap + 1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic stop_test();
		$display("Checks: %0d errors: %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test

	// AXI4-Lite write, address and data offered together
	task automatic axw(input logic [9:0] idx, input logic [31:0] v,
		output logic [1:0] r);
		logic done;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		done = 1'b0;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axw

	// AXI4-Lite read
	task automatic axr(input logic [9:0] idx, output logic [31:0] v,
		output logic [1:0] r);
		logic done;
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		done = 1'b0;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				v = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axr

	// Bounded wait for bias pin (sel 0) or signals (sel 1) to reach a level
	task automatic wait_lvl(input logic sel, input logic lvl);
		int t;
		for (t = 0; t < 300; t++)
		begin
			@(posedge aclk);
			#1;
			if ((sel ? panel_signals_en : panel_bias_enable_pin) === lvl)
				break;
		end
		if (t == 300)
			chk(32'h0, 32'h1);
	endtask : wait_lvl

	// Watchdog: twenty thousand cycles, far beyond the whole run
	initial
	begin
		#800000;
		errors++;
		stop_test();
	end

	initial
	begin
		seed = 32'h58;
		errors = 0;
		n_checks = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values, memory status starts at zero
		axr(psl_pkg::IDX_PS_STATE, rd, rs);
		chk(rd[0], 1'b0);
		axr(psl_pkg::IDX_PS_CFG, rd, rs);
		chk(rd, 32'h0);
		wait_lvl(1'b0, 1'b1);
		// Register masks with random data; unmapped place refused
		repeat (3)
		begin
			d = xs();
			axw(psl_pkg::IDX_REFRESH, d, rs);
			axr(psl_pkg::IDX_REFRESH, rd, rs);
			chk(rd, {24'h0, d[7:0] & psl_pkg::MASK_REFRESH});
			axw(psl_pkg::IDX_DUAL_BUF, d, rs);
			chk(dual_buf_dis, d[0]);
		end
		axr(10'h123, rd, rs);
		chk(rd, 32'h0);
		chk(rs, psl_pkg::RESP_SLVERR);
		axw(10'h123, 32'h0, rs);
		chk(rs, psl_pkg::RESP_SLVERR);
		// Blanking zeroes panel data, unblanking passes pixels
		axw(psl_pkg::IDX_DISP_MODE, 32'h80, rs);
		repeat (4)
		begin
			@(posedge aclk);
			#1;
			chk(panel_data, 16'h0);
		end
		axw(psl_pkg::IDX_DISP_MODE, 32'h0, rs);
		repeat (4)
		begin
			@(posedge aclk);
			#1;
			chk(panel_data, pix_d);
			chk(mem_grant, req_d);
		end
		// Manual bias control
		axw(psl_pkg::IDX_BIAS_CTRL, 32'h2, rs);
		#1;
		chk(panel_bias_enable_pin, 1'b0);
		axw(psl_pkg::IDX_BIAS_CTRL, 32'h3, rs);
		#1;
		chk(panel_bias_enable_pin, 1'b1);
		axw(psl_pkg::IDX_BIAS_CTRL, 32'h0, rs);
		// Power save with every refresh choice
		for (int s = 0; s < 4; s++)
		begin
			axw(psl_pkg::IDX_REFRESH, {24'h0, s[1:0], 6'h05}, rs);
			g0 = gap;
			axw(psl_pkg::IDX_PS_CFG, 32'h1, rs);
			wait_lvl(1'b1, 1'b0);
			chk(gap - g0, DLY + 1);
			axr(psl_pkg::IDX_PS_STATE, rd, rs);
			chk(rd, {30'h0, 1'b1, s != 0});
			chk(pix_clk_run, !rd[1]);
			chk(dram_cas_first_refresh, s == 0);
			chk(dram_self_refresh, s == 1);
			chk({display_en, mem_grant, panel_data}, 18'h0);
			chk(mem_refuse, req_d);
			chk(mem_clk_run, s == 0);
			axw(psl_pkg::IDX_PS_CFG, 32'h0, rs);
			axr(psl_pkg::IDX_PS_STATE, rd, rs);
			chk(rd, 32'h0);
			wait_lvl(1'b0, 1'b1);
			chk({display_en, memctl_down}, 2'b10);
		end
		chk(seq_fault, 1'b0);
		stop_test();
	end
endmodule : power_save_lcd_sequencer_tb
`default_nettype wire
